// ===== design/pcr_core.sv
// Core clock ratio control: select pins at boot, APB control register afterwards.
// Assumes pclk stands for the loop oscillator; select pins are asynchronous.
//
// Function
// RULE_01 - After power-up the select pins choose a core ratio of 32:1, 16:1 or 6:1.
// RULE_02 - After boot software may program any multiplier from 1 to 64.
// RULE_03 - The post-divide factor is 1, 2, 4 or 8 from the post-divider select field.
// RULE_04 - While reset holds the post-divide factor is 1 whatever the field says.
// RULE_05 - While reset holds the multiplier comes from the select pins, not software; the code holds RESET_MULT (6) until the pins are captured.
// RULE_06 - Oscillator is twice multiplier times loop input; core is that over twice factor.
// RULE_07 - Loop input is the reference clock, or half of it when the halver is on.
// RULE_08 - The peripheral clock period is exactly twice the core clock period.
// RULE_09 - The generated core clock times memory, processor core and serial ports.
// RULE_10 - Without halver software keeps reference times multiplier under half the limit.
// RULE_11 - With halver software keeps reference times multiplier under the limit.
// RULE_12 - Software keeps every loop change within the allowed core clock period.
// RULE_13 - Ratio changes never produce runt pulses on core or peripheral clocks.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
module pcr_core
  import pcr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  clock_ratio_select_pins,
  output logic             core_clock,
  output logic             peripheral_clock,
  output logic [6:0]       loop_multiplier,
  output logic [3:0]       post_divide_factor,
  output logic             input_halver_enable,
  output logic [7:0]       vco_ratio
);

  // Pin synchroniser and boot capture
  logic [1:0] pin_s1_q, pin_s2_q, pin_cap_q, pin_cap_d;
  logic [1:0] sync_cnt_q, sync_cnt_d;
  pcr_mode_e  mode_q, mode_d;

  // Register file and APB answer
  logic [9:0]  ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d;
  logic        err_q, err_d;

  // Applied configuration
  pcr_cfg_s   cfg_q, cfg_d, want;
  logic [7:0] vco_q, vco_d;
  logic [6:0] sw_mult, pin_mult;
  logic       bnd;
  logic       setup, wr_ctrl;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= clock_ratio_select_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_comb
  begin
    sync_cnt_d = sync_cnt_q;
    pin_cap_d  = pin_cap_q;
    mode_d     = mode_q;
    case (mode_q)
      MODE_BOOT_SYNC:
      begin
        // Pins are caught only once the synchroniser holds post-reset levels
        if (sync_cnt_q == SYNC_CYCLES)
        begin
          pin_cap_d = pin_s2_q;                                  // see RULE_01
          mode_d    = MODE_PIN_RATIO;
        end
        else
          sync_cnt_d = sync_cnt_q + 2'h1;
      end
      MODE_PIN_RATIO:
        if (ctrl_q[CTRL_SWSEL_BIT])
          mode_d = MODE_SW_RATIO;                                // see RULE_02
      MODE_SW_RATIO:
        if (!ctrl_q[CTRL_SWSEL_BIT])
          mode_d = MODE_PIN_RATIO;
      default:
        mode_d = MODE_BOOT_SYNC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_cnt_q <= 2'h0;
      pin_cap_q  <= 2'h0;
      mode_q     <= MODE_BOOT_SYNC;
    end
    else
    begin
      sync_cnt_q <= sync_cnt_d;
      pin_cap_q  <= pin_cap_d;
      mode_q     <= mode_d;
    end
  end

  // APB slave, one wait-free access phase
  always_comb
  begin
    setup   = psel && !penable;
    wr_ctrl = psel && penable && pwrite && (paddr == PCR_ADDR_CTRL);
    ctrl_d  = wr_ctrl ? pwdata[9:0] : ctrl_q;
    ready_d = setup;
    err_d   = setup && (paddr != PCR_ADDR_CTRL) && (paddr != PCR_ADDR_STATUS);
    rdata_d = 32'h0000_0000;
    if (setup && !pwrite && (paddr == PCR_ADDR_CTRL))
      rdata_d = {22'h00_0000, ctrl_q};
    else if (setup && !pwrite && (paddr == PCR_ADDR_STATUS))
    begin
      rdata_d[STAT_MULT_LSB +: 7]   = cfg_q.mult;
      rdata_d[STAT_FACTOR_LSB +: 4] = cfg_q.factor;
      rdata_d[STAT_HALVE_BIT]       = cfg_q.halver;
      rdata_d[STAT_SW_BIT]          = (mode_q == MODE_SW_RATIO);
      rdata_d[STAT_PINS_LSB +: 2]   = pin_cap_q;
      rdata_d[STAT_VCO_LSB +: 8]    = vco_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= CTRL_RESET;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  // Ratio selection
  always_comb
  begin
    // Field value 0 stands for 64 so the full 1..64 range fits six bits
    sw_mult = (ctrl_q[CTRL_MULT_LSB +: 6] == 6'h00) ? MULT_MAX
            : {1'b0, ctrl_q[CTRL_MULT_LSB +: 6]};                // see RULE_02
    case (pin_cap_q)
      2'h0:    pin_mult = PIN_RATIO_00;
      2'h1:    pin_mult = PIN_RATIO_01;
      2'h2:    pin_mult = PIN_RATIO_10;
      default: pin_mult = PIN_RATIO_11;
    endcase
    if (mode_q == MODE_SW_RATIO)
    begin
      want.mult   = sw_mult;
      want.factor = FACTOR_ONE << ctrl_q[CTRL_PDIV_LSB +: 2];    // see RULE_03
      want.halver = ctrl_q[CTRL_HALVE_BIT];                      // see RULE_07
    end
    else
    begin
      want.mult   = (mode_q == MODE_PIN_RATIO) ? pin_mult : RESET_MULT; // see RULE_05
      want.factor = FACTOR_ONE;                                  // see RULE_04
      want.halver = 1'b0;
    end
    // Change only at a clock boundary so the divider never sees a half-loaded set
    cfg_d = bnd ? want : cfg_q;                                  // see RULE_13
    // Oscillator over reference clock: 2*M, halved when the input halver is on
    vco_d = cfg_d.halver ? {1'b0, cfg_d.mult}
          : {cfg_d.mult, 1'b0};                                  // see RULE_06
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= '{mult: RESET_MULT, factor: FACTOR_ONE, halver: 1'b0};
      vco_q <= {RESET_MULT, 1'b0};
    end
    else
    begin
      cfg_q <= cfg_d;
      vco_q <= vco_d;
    end
  end

  // Core clock feeds memory, core and serial ports; peripheral clock is half of it
  pcr_clk_div u_div (                                            // see RULE_09
    .pclk             (pclk),
    .presetn          (presetn),
    .half_period      (cfg_q.factor),
    .core_clock       (core_clock),
    .peripheral_clock (peripheral_clock),
    .boundary         (bnd)
  );

  assign prdata              = rdata_q;
  assign pready              = ready_q;
  assign pslverr             = err_q;
  assign loop_multiplier     = cfg_q.mult;
  assign post_divide_factor  = cfg_q.factor;
  assign input_halver_enable = cfg_q.halver;
  assign vco_ratio           = vco_q;

  a_factor_legal: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_03
    cfg_q.factor inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("post-divide factor outside 1,2,4,8");

  a_pin_factor_one: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_04
    (mode_q != MODE_SW_RATIO) && bnd |=> cfg_q.factor == FACTOR_ONE)
    else $error("factor not 1 before software control");

  a_pin_ratio_used: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_05
    (mode_q == MODE_PIN_RATIO) && bnd |=> cfg_q.mult == $past(pin_mult))
    else $error("multiplier not taken from select pins");

  a_pin_ratio_set: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_01
    mode_q == MODE_PIN_RATIO |-> pin_mult inside {7'h20, 7'h10, 7'h06})
    else $error("pin ratio not 32, 16 or 6");

  a_mult_range: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    cfg_q.mult >= 7'h01 && cfg_q.mult <= MULT_MAX)
    else $error("multiplier outside 1..64");

  a_sw_applied: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    (mode_q == MODE_SW_RATIO) && bnd |=> cfg_q.mult == $past(sw_mult))
    else $error("software multiplier not applied at boundary");

  a_vco_ratio: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    vco_q == (cfg_q.halver ? {1'b0, cfg_q.mult} : {cfg_q.mult, 1'b0}))
    else $error("oscillator ratio wrong");

  a_halver_sw_only: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_07
    (mode_q != MODE_SW_RATIO) && bnd |=> !cfg_q.halver)
    else $error("halver on outside software control");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("access phase without ready");

endmodule

// ===== design/pcr_pkg.sv
// Constants, register map and carriers for the core clock ratio control block.
// Assumes a single 25 MHz APB clock; the loop itself is modelled as ratio settings.
package pcr_pkg;

  localparam logic [11:0] PCR_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] PCR_ADDR_STATUS = 12'h004;

  // Control register fields
  localparam int CTRL_MULT_LSB  = 0;
  localparam int CTRL_PDIV_LSB  = 6;
  localparam int CTRL_HALVE_BIT = 8;
  localparam int CTRL_SWSEL_BIT = 9;
  localparam logic [9:0] CTRL_RESET = 10'h010;

  // Status register fields
  localparam int STAT_MULT_LSB   = 0;
  localparam int STAT_FACTOR_LSB = 8;
  localparam int STAT_HALVE_BIT  = 12;
  localparam int STAT_SW_BIT     = 13;
  localparam int STAT_PINS_LSB   = 14;
  localparam int STAT_VCO_LSB    = 16;

  // Ratio picked by the select pins
  localparam logic [6:0] PIN_RATIO_00 = 7'h06;
  localparam logic [6:0] PIN_RATIO_01 = 7'h20;
  localparam logic [6:0] PIN_RATIO_10 = 7'h10;
  localparam logic [6:0] PIN_RATIO_11 = 7'h06;
  localparam logic [6:0] RESET_MULT   = 7'h06;
  localparam logic [6:0] MULT_MAX     = 7'h40;
  localparam logic [3:0] FACTOR_ONE   = 4'h1;
  localparam logic [1:0] SYNC_CYCLES  = 2'h2;

  typedef struct packed {
    logic [6:0] mult;
    logic [3:0] factor;
    logic       halver;
  } pcr_cfg_s;

  typedef enum logic [1:0] {
    MODE_BOOT_SYNC,
    MODE_PIN_RATIO,
    MODE_SW_RATIO
  } pcr_mode_e;

endpackage

// ===== design/pcr_clk_div.sv
// Glitch-free core and peripheral clock divider driven from the oscillator tick.
// Assumes half_period is 1, 2, 4 or 8 and may change at any time.
`timescale 1ns/10ps
module pcr_clk_div
  import pcr_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] half_period,
  output logic            core_clock,
  output logic            peripheral_clock,
  output logic            boundary
);

  logic [3:0] cnt_q,   cnt_d;
  logic [3:0] fac_q,   fac_d;
  logic       core_q,  core_d;
  logic       per_q,   per_d;
  logic       bnd_q,   bnd_d;
  logic [3:0] run_q,   run_d;
  logic       toggle;

  always_comb
  begin
    toggle = (cnt_q == fac_q - 4'h1);
    cnt_d  = toggle ? 4'h0 : cnt_q + 4'h1;
    core_d = toggle ? ~core_q : core_q;
    per_d  = (toggle && !core_q) ? ~per_q : per_q;             // see RULE_08
    bnd_d  = toggle && !core_q && per_q;
    // New factor only at a whole peripheral period, so no half period is cut short
    fac_d  = bnd_d ? half_period : fac_q;                      // see RULE_13
    // Cycles since the last core edge, kept only to check each half period
    run_d  = (core_d != core_q) ? 4'h0 : run_q + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 4'h0;
      fac_q  <= FACTOR_ONE;
      core_q <= 1'b0;
      per_q  <= 1'b0;
      bnd_q  <= 1'b0;
      run_q  <= 4'h0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      fac_q  <= fac_d;
      core_q <= core_d;
      per_q  <= per_d;
      bnd_q  <= bnd_d;
      run_q  <= run_d;
    end
  end

  assign core_clock       = core_q;
  assign peripheral_clock = per_q;
  assign boundary         = bnd_q;

  a_core_half_width: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_13
    $changed(core_q) |-> $past(run_q) == $past(fac_q) - 4'h1)
    else $error("core clock half period cut short");

  a_per_follows_core: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_08
    $changed(per_q) |-> $rose(core_q))
    else $error("peripheral clock moved without core rising edge");

endmodule

// ===== verif/pcr_core_tb.sv
// Self-checking bench for the core clock ratio control block.
// Assumes the APB slave answers in the first access cycle and ratios apply within 40 pclk.
`timescale 1ns/10ps
module pcr_core_tb
  import pcr_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pins;
  logic        core_clock;
  logic        peripheral_clock;
  logic [6:0]  loop_multiplier;
  logic [3:0]  post_divide_factor;
  logic        input_halver_enable;
  logic [7:0]  vco_ratio;
  int          errors;
  int          n_tests;

  pcr_core u_pcr_core (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .clock_ratio_select_pins (pins),
    .core_clock              (core_clock),
    .peripheral_clock        (peripheral_clock),
    .loop_multiplier         (loop_multiplier),
    .post_divide_factor      (post_divide_factor),
    .input_halver_enable     (input_halver_enable),
    .vco_ratio               (vco_ratio)
  );

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      errors++;
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for ready
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset is checked while still held, before the pins are captured
  task automatic do_reset(input logic [1:0] code);
    pins    <= code;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    check(loop_multiplier, 32'h0000_0006);
    check(post_divide_factor, 32'h0000_0001);
    check(vco_ratio, 32'h0000_000C);
    check({core_clock, peripheral_clock}, 0);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
  endtask

  // Counts pclk samples over one peripheral period, from rise to rise
  task automatic per_rise(output int per, output int hi);
    logic prev;
    per = 0;
    hi = 0;
    do
    begin
      prev = peripheral_clock;
      hi += (core_clock === 1'b1);
      per++;
      @(posedge pclk);
    end
    while (!(peripheral_clock === 1'b1 && prev === 1'b0) && per < 200);
  endtask

  task automatic t_pins();
    logic [6:0] exp_m [4];
    logic [31:0] rd;
    logic err;
    exp_m = '{PIN_RATIO_00, PIN_RATIO_01, PIN_RATIO_10, PIN_RATIO_11};
    for (int c = 0; c < 4; c++)
    begin
      do_reset(c[1:0]);
      check(loop_multiplier, exp_m[c]);
      check(vco_ratio, {exp_m[c], 1'b0});
      apb(1'b0, PCR_ADDR_CTRL, 0, rd, err);
      check(rd, 32'h0000_0010);
    end
    $display("test pins done");
  endtask

  task automatic t_soft();
    logic [5:0] code [4];
    logic [31:0] rd;
    logic [31:0] w;
    logic [6:0] m;
    logic [3:0] f;
    logic err;
    int per;
    int hi;
    // Ratios chosen to stay inside the oscillator limit
    code = '{6'h01, 6'h00, 6'h25, 6'h08};
    for (int d = 0; d < 4; d++)
    begin
      m = (code[d] == 0) ? 7'h40 : {1'b0, code[d]};
      f = 4'h1 << d;
      w = 32'h0000_0200 | (d << 6) | (d[0] << 8) | code[d];
      apb(1'b1, PCR_ADDR_CTRL, w, rd, err);
      repeat (40) @(posedge pclk);
      check(loop_multiplier, m);
      check(post_divide_factor, f);
      check(input_halver_enable, d[0]);
      check(vco_ratio, d[0] ? m : {m, 1'b0});
      per_rise(per, hi);
      per_rise(per, hi);
      check(per, 4 * f);
      check(hi, 2 * f);
      apb(1'b0, PCR_ADDR_STATUS, 0, rd, err);
      check(rd, (32'(d[0] ? m : 2 * m) << 16) | 32'h0000_E000 | (d[0] << 12)
            | (f << 8) | m);
    end
    apb(1'b1, PCR_ADDR_CTRL, 32'h0000_0000, rd, err);
    repeat (40) @(posedge pclk);
    check(loop_multiplier, PIN_RATIO_11);
    $display("test soft done");
  endtask

  task automatic t_bus();
    logic [31:0] rd;
    logic err;
    apb(1'b1, 12'h008, 32'h0000_03FF, rd, err);
    check(err, 1);
    apb(1'b1, PCR_ADDR_STATUS, 32'hFFFF_FFFF, rd, err);
    apb(1'b0, PCR_ADDR_CTRL, 0, rd, err);
    check(rd, 0);
    check(err, 0);
    apb(1'b0, 12'h008, 0, rd, err);
    check(err, 1);
    check(rd, 0);
    apb(1'b0, PCR_ADDR_STATUS, 0, rd, err);
    check(rd[13:0], 14'h0106);
    $display("test bus done");
  endtask

  initial
  begin
    errors  = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pins    = 2'b00;
    t_pins();
    t_soft();
    t_bus();
    wrap_up();
  end

  // Whole run is under a thousand cycles; this leaves wide margin
  initial
  begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule
